// ===== core/accl_top.sv
`timescale 1ns/10ps
// Summary of operation
// - result bit high while positive input exceeds negative input, otherwise low.
// - capture routing bit connects result to timer capture, else none.
// - routed result passes timer noise canceller and edge select like a pin.
// - power disable bit switches comparator off, changeable any time.
// - bandgap select replaces positive pin with internal reference.
// - raw output synchronised to clock with one to two cycles latency.
// - flag set when output event matches selected mode.
// - flag cleared when processor vectors to the handler.
// - writing one clears the flag, zero leaves it.
// - interrupt requested only with enable and global enable both set.
// - mode 00 toggle, 01 reserved, 10 falling, 11 rising.
// - mux enable with converter off routes converter mux to negative input.
// - channel field picks converter pin 0 to 7 as negative input.
// - mux disabled or converter enabled selects dedicated negative pin.
// - buffer-off bits disable pin input buffer; port bit reads zero.
module accl_top
  import accl_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  // clock, reset, enable
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [ADDR_W-1:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic hready_i,
  input wire logic [ACCL_DATA_W-1:0] hwdata_i,
  output logic [ACCL_DATA_W-1:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // analog comparator
  input wire logic comp_raw_i,
  output logic comp_power_down_o,
  output logic bandgap_select_o,
  output logic neg_from_mux_o,
  output logic [2:0] neg_channel_o,
  // converter state
  input wire logic converter_enable_i,
  input wire logic [2:0] channel_select_i,
  // timer capture front end
  output logic capture_route_o,
  output logic capture_input_o,
  // comparator pins digital path
  input wire logic [1:0] pin_raw_i,
  output logic [1:0] pin_buffer_off_o,
  output logic [1:0] pin_read_o,
  // processor interrupt
  input wire logic global_irq_enable_i,
  input wire logic irq_ack_i,
  output logic irq_req_o
);
  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic [ACCL_SYNC_STAGES-1:0] comp_sync_reg;
  logic [1:0] pin_sync1_reg;
  logic [1:0] pin_sync2_reg;
  logic power_disable_reg;
  logic bandgap_sel_reg;
  logic irq_flag_reg;
  logic irq_flag_next;
  logic irq_enable_reg;
  logic capture_route_reg;
  accl_mode_t mode_reg;
  logic mux_enable_reg;
  logic [1:0] buffer_off_reg;
  logic wr_pend_reg;
  logic rd_pend_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic addr_phase;
  logic wr_cs;
  logic wr_cb;
  logic wr_did;
  logic sel_cs;
  logic sel_cb;
  logic sel_did;
  logic [7:0] wbyte;
  logic result_bit;
  logic flag_clear;
  logic [7:0] cs_view;
  logic [7:0] cb_view;
  logic [7:0] did_view;
  logic [7:0] rd_byte;

  accl_edge_if edge_bus ();

  // reset release through two flip-flops
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_sync_reg <= 2'h0;
    end else if (ce_i) begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      comp_sync_reg <= '0;
      pin_sync1_reg <= 2'h0;
      pin_sync2_reg <= 2'h0;
    end else if (ce_i) begin
      comp_sync_reg <= {comp_sync_reg[ACCL_SYNC_STAGES-2:0], comp_raw_i};
      pin_sync1_reg <= pin_raw_i;
      pin_sync2_reg <= pin_sync1_reg;
    end
  end

  assign result_bit = comp_sync_reg[ACCL_SYNC_STAGES-1] & ~power_disable_reg;

  assign edge_bus.level = result_bit;
  assign edge_bus.active = ~power_disable_reg;
  assign edge_bus.mode = mode_reg;

  accl_edge_detect u_edge (
    .clk_i(mclk_i),
    .rst_n_i(rst_n),
    .ce_i(ce_i),
    .edge_if(edge_bus)
  );

  // ahb-lite address phase decode
  assign addr_phase = hsel_i & htrans_i[ACCL_HTRANS_ACTIVE_BIT] & hready_i;
  assign sel_cs = addr_reg == ADDR_W'(ACCL_OFS_CTRL_STATUS);
  assign sel_cb = addr_reg == ADDR_W'(ACCL_OFS_CONV_CTRL_B);
  assign sel_did = addr_reg == ADDR_W'(ACCL_OFS_DIG_IN_DIS);
  assign wr_cs = ce_i & wr_pend_reg & sel_cs;
  assign wr_cb = ce_i & wr_pend_reg & sel_cb;
  assign wr_did = ce_i & wr_pend_reg & sel_did;
  assign wbyte = hwdata_i[7:0];

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg <= '0;
    end else if (ce_i) begin
      wr_pend_reg <= addr_phase & hwrite_i;
      rd_pend_reg <= addr_phase & ~hwrite_i;
      if (addr_phase) begin
        addr_reg <= haddr_i;
      end
    end
  end

  // control bits
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      power_disable_reg <= ACCL_CS_RESET[ACCL_CS_POWER_DISABLE];
      bandgap_sel_reg <= ACCL_CS_RESET[ACCL_CS_BANDGAP_SEL];
      irq_enable_reg <= ACCL_CS_RESET[ACCL_CS_IRQ_ENABLE];
      capture_route_reg <= ACCL_CS_RESET[ACCL_CS_CAPTURE_ROUTE];
      mode_reg <= ACCL_CS_RESET[ACCL_CS_MODE_HI:ACCL_CS_MODE_LO];
    end else if (wr_cs) begin
      power_disable_reg <= wbyte[ACCL_CS_POWER_DISABLE];
      bandgap_sel_reg <= wbyte[ACCL_CS_BANDGAP_SEL];
      irq_enable_reg <= wbyte[ACCL_CS_IRQ_ENABLE];
      capture_route_reg <= wbyte[ACCL_CS_CAPTURE_ROUTE];
      mode_reg <= wbyte[ACCL_CS_MODE_HI:ACCL_CS_MODE_LO];
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      mux_enable_reg <= ACCL_CB_RESET[ACCL_CB_MUX_ENABLE];
      buffer_off_reg <= ACCL_DID_RESET[ACCL_DID_NEG_OFF:ACCL_DID_POS_OFF];
    end else begin
      if (wr_cb) begin
        mux_enable_reg <= wbyte[ACCL_CB_MUX_ENABLE];
      end
      if (wr_did) begin
        buffer_off_reg <= wbyte[ACCL_DID_NEG_OFF:ACCL_DID_POS_OFF];
      end
    end
  end

  assign flag_clear = (wr_cs & wbyte[ACCL_CS_IRQ_FLAG]) | (ce_i & irq_ack_i);

  // event sets flag, set wins over clear
  always_comb begin
    irq_flag_next = irq_flag_reg;
    if (flag_clear) begin
      irq_flag_next = 1'b0;
    end
    if (ce_i & edge_bus.event_p) begin
      irq_flag_next = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_flag_reg <= ACCL_CS_RESET[ACCL_CS_IRQ_FLAG];
    end else begin
      irq_flag_reg <= irq_flag_next;
    end
  end

  // register read views
  assign cs_view = {power_disable_reg, bandgap_sel_reg, result_bit, irq_flag_reg,
                    irq_enable_reg, capture_route_reg, mode_reg};
  assign cb_view = 8'(mux_enable_reg) << ACCL_CB_MUX_ENABLE;
  assign did_view = {6'h00, buffer_off_reg};
  assign rd_byte = sel_cs ? cs_view : sel_cb ? cb_view : sel_did ? did_view : 8'h00;
  assign hrdata_o = rd_pend_reg ? {24'h000000, rd_byte} : '0;
  assign hreadyout_o = ce_i;
  assign hresp_o = 1'b0;

  assign irq_req_o = irq_flag_reg & irq_enable_reg & global_irq_enable_i;

  // synchronised result into capture front end
  assign capture_route_o = capture_route_reg;
  assign capture_input_o = capture_route_reg & result_bit;

  assign comp_power_down_o = power_disable_reg;
  assign bandgap_select_o = bandgap_sel_reg;

  assign neg_from_mux_o = mux_enable_reg & ~converter_enable_i;
  assign neg_channel_o = channel_select_i;

  assign pin_buffer_off_o = buffer_off_reg;
  assign pin_read_o = pin_sync2_reg & ~buffer_off_reg;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n);

  a_result_off_low: assert property (power_disable_reg |-> !result_bit && !edge_bus.event_p)
    else $error("result or event active while powered off");
  a_sync_latency: assert property ((ce_i && !power_disable_reg)[*3]
      |-> result_bit == $past(comp_raw_i, 2))
    else $error("result does not follow raw output after two cycles");
  a_capture_gated: assert property (!capture_route_reg |-> !capture_input_o)
    else $error("capture driven while not routed");
  a_capture_follow: assert property (capture_route_reg |-> capture_input_o == result_bit)
    else $error("capture input differs from result");
  a_flag_set: assert property (ce_i && edge_bus.event_p |=> irq_flag_reg)
    else $error("event did not set flag");
  a_flag_wclear: assert property (wr_cs && wbyte[ACCL_CS_IRQ_FLAG] && !edge_bus.event_p
      |=> !irq_flag_reg)
    else $error("write one did not clear flag");
  a_flag_wzero: assert property (wr_cs && !wbyte[ACCL_CS_IRQ_FLAG] && !irq_ack_i
      && irq_flag_reg |=> irq_flag_reg)
    else $error("write zero disturbed flag");
  a_flag_ack: assert property (ce_i && irq_ack_i && !edge_bus.event_p |=> !irq_flag_reg)
    else $error("vector acknowledge did not clear flag");
  a_irq_gate: assert property (irq_req_o |-> irq_enable_reg && global_irq_enable_i
      && irq_flag_reg)
    else $error("interrupt requested without enables");
  a_neg_pin: assert property (!mux_enable_reg || converter_enable_i |-> !neg_from_mux_o)
    else $error("mux selected while disallowed");
  a_neg_mux: assert property (mux_enable_reg && !converter_enable_i
      |-> neg_from_mux_o && neg_channel_o == channel_select_i)
    else $error("mux not selected when allowed");
  a_pin_zero: assert property (buffer_off_reg[ACCL_DID_POS_OFF]
      |-> !pin_read_o[ACCL_DID_POS_OFF])
    else $error("disabled pin reads one");
  a_bandgap_sel: assert property (wr_cs |=> bandgap_select_o == $past(wbyte[ACCL_CS_BANDGAP_SEL]))
    else $error("bandgap select not taken");

  c_flag_raised: cover property (irq_req_o);
  c_capture_pulse: cover property (capture_route_reg && $rose(capture_input_o));
  c_mux_select: cover property (neg_from_mux_o && neg_channel_o == 3'h7);
endmodule

// ===== inc/accl_pkg.sv
package accl_pkg;
  // bus geometry
  localparam int ACCL_DATA_W = 32;
  localparam int ACCL_REG_W = 8;
  localparam int ACCL_HTRANS_ACTIVE_BIT = 1;
  // register byte offsets
  localparam logic [7:0] ACCL_OFS_CTRL_STATUS = 8'h00;
  localparam logic [7:0] ACCL_OFS_CONV_CTRL_B = 8'h04;
  localparam logic [7:0] ACCL_OFS_DIG_IN_DIS = 8'h08;
  // comparator_control_status fields
  localparam int ACCL_CS_POWER_DISABLE = 7;
  localparam int ACCL_CS_BANDGAP_SEL = 6;
  localparam int ACCL_CS_RESULT = 5;
  localparam int ACCL_CS_IRQ_FLAG = 4;
  localparam int ACCL_CS_IRQ_ENABLE = 3;
  localparam int ACCL_CS_CAPTURE_ROUTE = 2;
  localparam int ACCL_CS_MODE_HI = 1;
  localparam int ACCL_CS_MODE_LO = 0;
  // converter_control_b and digital_input_disable_one fields
  localparam int ACCL_CB_MUX_ENABLE = 6;
  localparam int ACCL_DID_NEG_OFF = 1;
  localparam int ACCL_DID_POS_OFF = 0;
  // reset values
  localparam logic [7:0] ACCL_CS_RESET = 8'h00;
  localparam logic [7:0] ACCL_CB_RESET = 8'h00;
  localparam logic [7:0] ACCL_DID_RESET = 8'h00;
  // synchroniser depth
  localparam int ACCL_SYNC_STAGES = 2;
  // interrupt mode encodings
  typedef logic [1:0] accl_mode_t;
  localparam accl_mode_t ACCL_MODE_TOGGLE = 2'h0;
  localparam accl_mode_t ACCL_MODE_RESERVED = 2'h1;
  localparam accl_mode_t ACCL_MODE_FALL = 2'h2;
  localparam accl_mode_t ACCL_MODE_RISE = 2'h3;
endpackage

// ===== inc/accl_edge_if.sv
`timescale 1ns/10ps
interface accl_edge_if;
  import accl_pkg::*;
  logic level;
  logic active;
  accl_mode_t mode;
  logic event_p;
  modport src (output level, output active, output mode, input event_p);
  modport det (input level, input active, input mode, output event_p);
endinterface

// ===== core/accl_edge_detect.sv
`timescale 1ns/10ps
module accl_edge_detect
  import accl_pkg::*;
(
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // comparator level and event
  accl_edge_if.det edge_if
);
  logic prev_reg;
  logic rise;
  logic fall;
  logic sel_event;

  assign rise = edge_if.level & ~prev_reg;
  assign fall = ~edge_if.level & prev_reg;

  always_comb begin
    unique case (edge_if.mode)
      ACCL_MODE_TOGGLE: sel_event = rise | fall;
      ACCL_MODE_RESERVED: sel_event = 1'b0;
      ACCL_MODE_FALL: sel_event = fall;
      ACCL_MODE_RISE: sel_event = rise;
    endcase
  end

  assign edge_if.event_p = edge_if.active & sel_event;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_reg <= 1'b0;
    end else if (ce_i) begin
      prev_reg <= edge_if.level;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_reserved_quiet: assert property (edge_if.mode == ACCL_MODE_RESERVED |-> !edge_if.event_p)
    else $error("event raised in reserved mode");
  a_rise_event: assert property (ce_i && edge_if.active && edge_if.mode == ACCL_MODE_RISE
      && !edge_if.level ##1 edge_if.active && edge_if.level && edge_if.mode == ACCL_MODE_RISE
      |-> edge_if.event_p)
    else $error("rising edge missed");
  a_fall_only: assert property (edge_if.mode == ACCL_MODE_FALL && edge_if.level
      |-> !edge_if.event_p)
    else $error("falling mode fired on high level");
  c_toggle_event: cover property (edge_if.mode == ACCL_MODE_TOGGLE && edge_if.event_p);
endmodule

// ===== testbench/accl_analog_model.sv
`timescale 1ns/10ps
module accl_analog_model (
  // clock
  input wire logic mclk_i,
  // comparator control
  input wire logic power_down_i,
  input wire logic bandgap_sel_i,
  input wire logic neg_from_mux_i,
  input wire logic [2:0] neg_channel_i,
  input wire logic capture_input_i,
  // pin voltages in millivolts
  input wire logic [15:0] pos_mv_i,
  input wire logic [15:0] neg_mv_i,
  input wire logic [15:0] bandgap_mv_i,
  input wire logic [7:0][15:0] conv_mv_i,
  // comparator and timer capture
  output logic comp_raw_o,
  output logic [7:0] capture_edges_o
);
  logic [15:0] plus_mv;
  logic [15:0] minus_mv;
  logic wander = 1'b0;
  logic cap_q = 1'b0;
  logic [7:0] edge_cnt = 8'h00;
  assign plus_mv = bandgap_sel_i ? bandgap_mv_i : pos_mv_i;
  assign minus_mv = neg_from_mux_i ? conv_mv_i[neg_channel_i] : neg_mv_i;
  assign comp_raw_o = power_down_i ? wander : (plus_mv > minus_mv);
  assign capture_edges_o = edge_cnt;
  always @(posedge mclk_i) begin
    wander <= ~wander;
    cap_q <= capture_input_i;
    if (capture_input_i && !cap_q) begin
      edge_cnt <= edge_cnt + 8'h01;
    end
  end
endmodule

// ===== testbench/testbench.sv
`timescale 1ns/10ps
module testbench;
  import accl_pkg::*;
  logic mclk_i, reset_n_i, ce_i, hsel_i, hwrite_i, hready_i, hreadyout_o, hresp_o;
  logic [7:0] haddr_i;
  logic [1:0] htrans_i, pin_raw_i, pin_buffer_off_o, pin_read_o;
  logic [2:0] hsize_i, neg_channel_o, channel_select_i;
  logic [31:0] hwdata_i, hrdata_o, rd;
  logic comp_raw_i, comp_power_down_o, bandgap_select_o, neg_from_mux_o, converter_enable_i;
  logic capture_route_o, capture_input_o, global_irq_enable_i, irq_ack_i, irq_req_o;
  logic [15:0] pos_mv, neg_mv, bg_mv;
  logic [7:0][15:0] conv_mv;
  logic [7:0] cap_n;
  int errors, comparisons;
  assign hready_i = hreadyout_o;
  accl_top dut_u (.mclk_i, .reset_n_i, .ce_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i,
    .hready_i, .hwdata_i, .hrdata_o, .hreadyout_o, .hresp_o, .comp_raw_i, .comp_power_down_o,
    .bandgap_select_o, .neg_from_mux_o, .neg_channel_o, .converter_enable_i, .channel_select_i,
    .capture_route_o, .capture_input_o, .pin_raw_i, .pin_buffer_off_o, .pin_read_o,
    .global_irq_enable_i, .irq_ack_i, .irq_req_o);
  accl_analog_model model_u (.mclk_i, .power_down_i(comp_power_down_o),
    .bandgap_sel_i(bandgap_select_o), .neg_from_mux_i(neg_from_mux_o),
    .neg_channel_i(neg_channel_o), .capture_input_i(capture_input_o), .pos_mv_i(pos_mv),
    .neg_mv_i(neg_mv), .bandgap_mv_i(bg_mv), .conv_mv_i(conv_mv), .comp_raw_o(comp_raw_i),
    .capture_edges_o(cap_n));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (hreadyout_o !== 1'b1 && n < 50);
    if (hreadyout_o !== 1'b1) begin
      errors++;
      complete_run;
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i <= a;
    hwrite_i <= wr;
    wait_ready;
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= {24'h0, d};
    wait_ready;
    rd = hrdata_o;
    check(hresp_o, 32'h0);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 8'h00);
    check(rd & m, e);
  endtask
  task automatic reset_map;
    rd_chk(8'h00, 32'hFFFFFFFF, 32'h0); // low result
    rd_chk(8'h04, 32'hFFFFFFFF, 32'h0);
    bus(1'b1, 8'h04, 8'hFF);
    rd_chk(8'h04, 32'hFFFFFFFF, 32'h40); // mux enable bit
    bus(1'b1, 8'h04, 8'h00);
    bus(1'b1, 8'h0C, 8'hFF);
    rd_chk(8'h0C, 32'hFFFFFFFF, 32'h0);
  endtask
  task automatic mode_events;
    logic [3:0] on_rise;
    logic [3:0] on_fall;
    on_rise = 4'b1001;
    on_fall = 4'b0101;
    // enable stays off while mode changes
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, 8'h00, 8'h10 | 8'(m));
      pos_mv <= 16'd200;
      tick(4);
      rd_chk(8'h00, 32'hFF, 32'h20 | 32'(on_rise[m]) << 4 | 32'(m));
      bus(1'b1, 8'h00, 8'h10 | 8'(m));
      pos_mv <= 16'd0;
      tick(4);
      rd_chk(8'h00, 32'hFF, 32'(on_fall[m]) << 4 | 32'(m)); // fall
    end
  endtask
  task automatic irq_paths;
    bus(1'b1, 8'h00, 8'h1B);
    pos_mv <= 16'd200;
    tick(4);
    check(irq_req_o, 32'h0); // global off
    global_irq_enable_i <= 1'b1;
    tick(1);
    check(irq_req_o, 32'h1); // both on
    irq_ack_i <= 1'b1;
    tick(1);
    irq_ack_i <= 1'b0;
    tick(1);
    check(irq_req_o, 32'h0); // ack clears
    pos_mv <= 16'd0;
    tick(4);
    pos_mv <= 16'd200;
    tick(4);
    bus(1'b1, 8'h00, 8'h0B);
    rd_chk(8'h00, 32'h10, 32'h10); // zero keeps
    bus(1'b1, 8'h00, 8'h1B);
    rd_chk(8'h00, 32'h10, 32'h0); // one clears
    global_irq_enable_i <= 1'b0;
    bus(1'b1, 8'h00, 8'h03);
    bus(1'b1, 8'h00, 8'h00);
    pos_mv <= 16'd0;
    tick(4);
  endtask
  task automatic mux_select;
    logic [7:0][15:0] mv;
    pos_mv <= 16'd500;
    // converter power reduction taken as cleared
    neg_mv <= 16'd900;
    bus(1'b1, 8'h04, 8'h40);
    for (int c = 0; c < 8; c++) begin
      mv = {8{16'd1000}};
      mv[c] = 16'd100;
      converter_enable_i <= 1'b0;
      channel_select_i <= 3'(c);
      conv_mv <= mv;
      tick(4);
      check({neg_from_mux_o, neg_channel_o}, 32'h8 | 32'(c)); // mux route
      rd_chk(8'h00, 32'h20, 32'h20); // picked pin
      converter_enable_i <= 1'b1;
      tick(4);
      check(neg_from_mux_o, 32'h0); // converter on
      rd_chk(8'h00, 32'h20, 32'h0); // dedicated pin
    end
    converter_enable_i <= 1'b0;
    bus(1'b1, 8'h04, 8'h00);
    tick(4);
    rd_chk(8'h00, 32'h20, 32'h0); // mux off
    pos_mv <= 16'd0;
    neg_mv <= 16'd100;
    tick(4);
  endtask
  task automatic power_path;
    pos_mv <= 16'd200;
    bus(1'b1, 8'h00, 8'h80);
    bus(1'b1, 8'h00, 8'h90);
    tick(10);
    check(comp_power_down_o, 32'h1); // power off
    rd_chk(8'h00, 32'hFF, 32'h80); // no result no flag
    pos_mv <= 16'd0;
    bg_mv <= 16'd1200;
    bus(1'b1, 8'h00, 8'h50);
    tick(4);
    check(bandgap_select_o, 32'h1); // bandgap bit
    rd_chk(8'h00, 32'hE0, 32'h60); // bandgap wins
    bus(1'b1, 8'h00, 8'h00);
    tick(4);
  endtask
  task automatic capture_path;
    logic [7:0] n0;
    bus(1'b1, 8'h00, 8'h14);
    n0 = cap_n;
    repeat (3) begin
      pos_mv <= 16'd200;
      tick(4);
      check(capture_input_o, 32'h1); // routed
      pos_mv <= 16'd0;
      tick(4);
    end
    check(cap_n, n0 + 3); // capture edges
    bus(1'b1, 8'h00, 8'h10);
    pos_mv <= 16'd200;
    tick(4);
    check({capture_route_o, capture_input_o}, 32'h0); // not routed
    check(cap_n, n0 + 3); // no capture
    pos_mv <= 16'd0;
    tick(4);
  endtask
  task automatic pin_buffers;
    pin_raw_i <= 2'h3;
    tick(4);
    check(pin_read_o, 32'h3); // buffers on
    bus(1'b1, 8'h08, 8'h03);
    tick(1);
    check({pin_buffer_off_o, pin_read_o}, 32'hC); // both off
    bus(1'b1, 8'h08, 8'h01);
    tick(3);
    check({pin_buffer_off_o, pin_read_o}, 32'h6); // positive off
    rd_chk(8'h08, 32'hFF, 32'h1); // readback
  endtask
  task automatic ce_freeze;
    ce_i <= 1'b0;
    pin_raw_i <= 2'h0;
    tick(4);
    check(hreadyout_o, 32'h0); // stalled bus
    check(pin_read_o, 32'h2); // frozen pins
    ce_i <= 1'b1;
    tick(4);
    check(pin_read_o, 32'h0); // pins resume
  endtask
  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end
  initial begin
    {reset_n_i, hsel_i, hwrite_i, converter_enable_i, global_irq_enable_i, irq_ack_i} = '0;
    ce_i = 1'b1;
    hsize_i = 3'h2;
    haddr_i = 8'h00;
    htrans_i = 2'h0;
    hwdata_i = 32'h0;
    channel_select_i = 3'h0;
    pin_raw_i = 2'h0;
    {pos_mv, bg_mv} = '0;
    neg_mv = 16'd100;
    conv_mv = {8{16'd1000}};
    errors = 0;
    comparisons = 0;
    tick(16);
    reset_n_i <= 1'b1;
    tick(3);
    reset_map;
    mode_events;
    irq_paths;
    mux_select;
    power_path;
    capture_path;
    pin_buffers;
    ce_freeze;
    complete_run;
  end
endmodule
